// ---- hdl/fbds_pkg.sv ----
// package: shared constants and types for the full-bridge drive sequencer
package fbds_pkg;
  // dead time per variant, in ns (1.0 us and 0.5 us)
  localparam int DEAD_LONG_NS = 1000;
  localparam int DEAD_SHORT_NS = 500;
  localparam int CLOCK_PERIOD_NS = 5;
  // least time rounds up to whole cycles
  localparam int DEAD_LONG_CYC = (DEAD_LONG_NS + CLOCK_PERIOD_NS - 1) /
                                 CLOCK_PERIOD_NS;
  localparam int DEAD_SHORT_CYC = (DEAD_SHORT_NS + CLOCK_PERIOD_NS - 1) /
                                  CLOCK_PERIOD_NS;
  localparam int CNT_W = 16;
  localparam logic [1:0] RST_SYNC_INIT = 2'h0;

  typedef enum logic [2:0] {
    FBDS_LOCKOUT,
    FBDS_PRECHARGE,
    FBDS_DEAD_A,
    FBDS_PAIR_A,
    FBDS_DEAD_B,
    FBDS_PAIR_B,
    FBDS_HALT,
    FBDS_FAULT
  } fbds_state_t;
endpackage

// ---- hdl/fbds_dead_timer.sv ----
// dead-time counter: counts a fixed number of cycles after a start pulse
`timescale 1ns/1ps
module fbds_dead_timer #(
  parameter int CYCLES = fbds_pkg::DEAD_LONG_CYC
) (
  input wire logic clock,
  input wire logic rstN,
  input wire logic start,
  input wire logic abort,
  output logic done
);
  localparam int CW = fbds_pkg::CNT_W;
  // cut on purpose: counts stay far below the counter range
  localparam logic [CW-1:0] LOAD = CW'(CYCLES - 1);
  localparam logic [fbds_pkg::CNT_W-1:0] ZERO = '0;

  logic [fbds_pkg::CNT_W-1:0] count_ff;
  logic running_ff;
  logic [fbds_pkg::CNT_W-1:0] nxt_count;
  logic nxt_running;
  wire expire = running_ff && (count_ff == ZERO);

  assign done = expire && !start && !abort;
  assign nxt_running = start ? 1'b1 : ((abort || expire) ? 1'b0 : running_ff);
  assign nxt_count = start ? LOAD :
                     (running_ff && !expire ? count_ff - 1'b1 : count_ff);

  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      count_ff <= ZERO;
      running_ff <= 1'b0;
    end else begin
      count_ff <= nxt_count;
      running_ff <= nxt_running;
    end
  end
endmodule

// ---- hdl/fbds_gate_stage.sv ----
// gate stage: registered outputs with per-leg interlock and bootstrap enable
`timescale 1ns/1ps
module fbds_gate_stage (
  input wire logic clock,
  input wire logic rstN,
  input wire logic wantLow1,
  input wire logic wantLow2,
  input wire logic wantHigh1,
  input wire logic wantHigh2,
  output logic lowSideGateOne,
  output logic lowSideGateTwo,
  output logic highSideGateOne,
  output logic highSideGateTwo,
  output logic bootstrapOne,
  output logic bootstrapTwo
);
  logic lowOne_ff, lowTwo_ff, highOne_ff, highTwo_ff;
  // low side wins a conflict: never both on one leg
  wire nxtHighOne = wantHigh1 && !wantLow1;
  wire nxtHighTwo = wantHigh2 && !wantLow2;

  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      lowOne_ff <= 1'b0;
      lowTwo_ff <= 1'b0;
      highOne_ff <= 1'b0;
      highTwo_ff <= 1'b0;
    end else begin
      lowOne_ff <= wantLow1;
      lowTwo_ff <= wantLow2;
      highOne_ff <= nxtHighOne;
      highTwo_ff <= nxtHighTwo;
    end
  end

  assign lowSideGateOne = lowOne_ff;
  assign lowSideGateTwo = lowTwo_ff;
  assign highSideGateOne = highOne_ff;
  assign highSideGateTwo = highTwo_ff;
  // bootstrap switch follows its own leg's low side
  assign bootstrapOne = lowOne_ff;
  assign bootstrapTwo = lowTwo_ff;
endmodule

// ---- hdl/fbds_sequencer.sv ----
// top: full-bridge drive sequencer state machine
// Functional notes
// - lockout holds all four gates low
// - leaving lockout starts oscillation
// - resistor drive high on leaving lockout
// - lower level: pair one after dead time
// - upper level: swap pairs, resistor low
// - falling lower level: swap back, resistor high
// - dead time 1.0 or 0.5 us
// - bootstrap only while own low side high
// - both low sides high during precharge ramp
// - ramp below shutdown level stops, highs low
// - lows stay high below lower level
// - ramp release resumes from precharge
// - latched shutdown forces fault, all low
// - fault cleared only by supply recycle
`timescale 1ns/1ps
module fbds_sequencer #(
  parameter bit SHORT_DEAD = 1'b0
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic supplyLockoutState,
  input wire logic rampAboveLower,
  input wire logic rampAboveUpper,
  input wire logic rampBelowShutdown,
  input wire logic latchedShutdownIn,
  output logic lowSideGateOne,
  output logic lowSideGateTwo,
  output logic highSideGateOne,
  output logic highSideGateTwo,
  output logic bootstrapOne,
  output logic bootstrapTwo,
  output logic timingResistorDrive,
  output logic faultActive
);
  localparam int DEAD_CYC = SHORT_DEAD ? fbds_pkg::DEAD_SHORT_CYC :
                                         fbds_pkg::DEAD_LONG_CYC;

  ////////////////////////////////////////////////////////////////////////
  logic [1:0] rstSync_ff;
  wire rstN = rstSync_ff[1];

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rstSync_ff <= fbds_pkg::RST_SYNC_INIT;
    end else begin
      rstSync_ff <= {rstSync_ff[0], 1'b1};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  fbds_pkg::fbds_state_t state_ff, nxt_state;
  logic resDrive_ff, nxt_resDrive;
  logic deadStart;
  logic deadDone;
  wire deadAbort;

  // inputs are used directly as synchronous levels
  wire inLockout = supplyLockoutState;
  wire shutTrip = latchedShutdownIn;
  wire haltReq = rampBelowShutdown;

  assign deadAbort = inLockout || shutTrip || haltReq;

  fbds_dead_timer #(
    .CYCLES(DEAD_CYC)
  ) uDead (
    .clock(clock),
    .rstN(rstN),
    .start(deadStart),
    .abort(deadAbort),
    .done(deadDone)
  );

  always_comb begin
    nxt_state = state_ff;
    nxt_resDrive = resDrive_ff;
    deadStart = 1'b0;
    case (state_ff)
      fbds_pkg::FBDS_LOCKOUT: begin
        nxt_resDrive = 1'b0;
        if (!inLockout) begin
          nxt_state = fbds_pkg::FBDS_PRECHARGE;
          nxt_resDrive = 1'b1;
        end
      end
      fbds_pkg::FBDS_PRECHARGE: begin
        if (rampAboveLower && !haltReq) begin
          nxt_state = fbds_pkg::FBDS_DEAD_A;
          deadStart = 1'b1;
        end
      end
      fbds_pkg::FBDS_DEAD_A: begin
        if (deadDone) begin
          nxt_state = fbds_pkg::FBDS_PAIR_A;
        end
      end
      fbds_pkg::FBDS_PAIR_A: begin
        if (rampAboveUpper) begin
          nxt_state = fbds_pkg::FBDS_DEAD_B;
          nxt_resDrive = 1'b0;
          deadStart = 1'b1;
        end
      end
      fbds_pkg::FBDS_DEAD_B: begin
        if (deadDone) begin
          nxt_state = fbds_pkg::FBDS_PAIR_B;
        end
      end
      fbds_pkg::FBDS_PAIR_B: begin
        if (!rampAboveLower) begin
          nxt_state = fbds_pkg::FBDS_DEAD_A;
          nxt_resDrive = 1'b1;
          deadStart = 1'b1;
        end
      end
      fbds_pkg::FBDS_HALT: begin
        nxt_resDrive = 1'b1;
        // released ramp restarts at the precharge phase
        if (!haltReq) begin
          nxt_state = fbds_pkg::FBDS_PRECHARGE;
        end
      end
      fbds_pkg::FBDS_FAULT: begin
        nxt_resDrive = 1'b0;
      end
      default: begin
        nxt_state = fbds_pkg::FBDS_LOCKOUT;
        nxt_resDrive = 1'b0;
      end
    endcase
    // priority: lockout over fault over halt
    if (state_ff != fbds_pkg::FBDS_LOCKOUT &&
        state_ff != fbds_pkg::FBDS_FAULT && haltReq && !shutTrip) begin
      nxt_state = fbds_pkg::FBDS_HALT;
      nxt_resDrive = 1'b1;
      deadStart = 1'b0;
    end
    if (shutTrip && state_ff != fbds_pkg::FBDS_LOCKOUT) begin
      nxt_state = fbds_pkg::FBDS_FAULT;
      nxt_resDrive = 1'b0;
      deadStart = 1'b0;
    end
    if (inLockout) begin
      // only a trip through lockout leaves the fault state
      nxt_state = fbds_pkg::FBDS_LOCKOUT;
      nxt_resDrive = 1'b0;
      deadStart = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      state_ff <= fbds_pkg::FBDS_LOCKOUT;
      resDrive_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      resDrive_ff <= nxt_resDrive;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // gate wishes from the next state so outputs align with it
  wire sLock = nxt_state == fbds_pkg::FBDS_LOCKOUT;
  wire sFault = nxt_state == fbds_pkg::FBDS_FAULT;
  wire sPre = nxt_state == fbds_pkg::FBDS_PRECHARGE;
  wire sHalt = nxt_state == fbds_pkg::FBDS_HALT;
  wire sPairA = nxt_state == fbds_pkg::FBDS_PAIR_A;
  wire sPairB = nxt_state == fbds_pkg::FBDS_PAIR_B;
  wire allOff = sLock || sFault;
  // halted ramp is below lower level, so lows stay on
  wire bothLow = sPre || sHalt;

  wire wantLow1 = !allOff && (bothLow || sPairA);
  wire wantLow2 = !allOff && (bothLow || sPairB);
  wire wantHigh1 = !allOff && sPairB;
  wire wantHigh2 = !allOff && sPairA;

  fbds_gate_stage uGate (
    .clock(clock),
    .rstN(rstN),
    .wantLow1(wantLow1),
    .wantLow2(wantLow2),
    .wantHigh1(wantHigh1),
    .wantHigh2(wantHigh2),
    .lowSideGateOne(lowSideGateOne),
    .lowSideGateTwo(lowSideGateTwo),
    .highSideGateOne(highSideGateOne),
    .highSideGateTwo(highSideGateTwo),
    .bootstrapOne(bootstrapOne),
    .bootstrapTwo(bootstrapTwo)
  );

  assign timingResistorDrive = resDrive_ff;
  assign faultActive = state_ff == fbds_pkg::FBDS_FAULT;
endmodule

// ---- testbench/fbds_ramp_model.sv ----
// ramp model: timing capacitor and its comparators
`timescale 1ns/1ps
module fbds_ramp_model #(
  parameter int TOP = 600
) (
  input wire logic clock,
  input wire logic drive,
  input wire logic pull,
  input wire logic uv,
  output logic aboveLower,
  output logic aboveUpper,
  output logic belowShutdown
);
  int lvl = 0;
  // one count a cycle; release of pull lets it climb again
  always @(negedge clock) begin
    if (pull || uv)
      lvl <= 0;
    else if (drive && lvl < TOP)
      lvl <= lvl + 1;
    else if (!drive && lvl > 0)
      lvl <= lvl - 1;
  end
  assign aboveLower = lvl >= TOP / 3;
  assign aboveUpper = lvl >= 2 * TOP / 3;
  assign belowShutdown = lvl < TOP / 6;
endmodule

// ---- testbench/fbds_sequencer_checker.sv ----
// checker: port assertions for the drive sequencer
`timescale 1ns/1ps
module fbds_sequencer_checker #(
  parameter bit SHORT_DEAD = 1'b0
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic supplyLockoutState,
  input wire logic rampAboveLower,
  input wire logic rampAboveUpper,
  input wire logic rampBelowShutdown,
  input wire logic latchedShutdownIn,
  input wire logic lowSideGateOne,
  input wire logic lowSideGateTwo,
  input wire logic highSideGateOne,
  input wire logic highSideGateTwo,
  input wire logic bootstrapOne,
  input wire logic bootstrapTwo,
  input wire logic timingResistorDrive,
  input wire logic faultActive
);
  localparam int DLO = (SHORT_DEAD ? fbds_pkg::DEAD_SHORT_CYC :
    fbds_pkg::DEAD_LONG_CYC) - 1;
  localparam int DHI = DLO + 3;
  logic [1:0] up_ff;
  // reset is synced inside, so inputs count from the third edge
  wire armed = up_ff == 2'h3;
  wire calm = armed & !supplyLockoutState & !latchedShutdownIn;
  wire anyGate = lowSideGateOne | lowSideGateTwo | highSideGateOne |
    highSideGateTwo;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst)
      up_ff <= 2'h0;
    else if (!armed)
      up_ff <= up_ff + 2'h1;
  end
  ////////////////////////////////////////
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  lock_low_a: assert property (supplyLockoutState |=> !anyGate)
    else $error("gate high in lockout");
  leg_excl_a: assert property (!(lowSideGateOne && highSideGateOne) &&
    !(lowSideGateTwo && highSideGateTwo)) else $error("leg overlap");
  boot_follow_a: assert property (bootstrapOne == lowSideGateOne &&
    bootstrapTwo == lowSideGateTwo) else $error("bootstrap mismatch");
  fault_low_a: assert property (faultActive |-> !anyGate)
    else $error("gate high in fault");
  // the lockout state ignores shutdown for the one edge it takes to leave
  shut_fault_a: assert property (armed && latchedShutdownIn &&
    !supplyLockoutState && !$past(supplyLockoutState) |=> faultActive)
    else $error("no fault");
  fault_hold_a: assert property (faultActive && !supplyLockoutState
    |=> faultActive) else $error("fault cleared");
  halt_out_a: assert property (calm && rampBelowShutdown &&
    !faultActive |=> lowSideGateOne && lowSideGateTwo && !highSideGateOne
    && !highSideGateTwo) else $error("bad halt outputs");
  pair_time_a: assert property (calm && !rampBelowShutdown &&
    $rose(rampAboveLower) && lowSideGateOne && lowSideGateTwo |-> ##[DLO:DHI]
    (lowSideGateOne && highSideGateTwo)) else $error("pair late");
  ramp_discharge_a: assert property (calm && $rose(rampAboveUpper) &&
    highSideGateTwo |=> !timingResistorDrive && !anyGate)
    else $error("no discharge");
endmodule

// ---- testbench/tb.sv ----
// testbench: mode table, oscillation and reset cases
`timescale 1ns/1ps
module tb;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic supplyLockoutState = 1'b1;
  logic latchedShutdownIn = 1'b0;
  logic pull = 1'b0;
  logic rampAboveLower, rampAboveUpper, rampBelowShutdown;
  logic lowSideGateOne, lowSideGateTwo, highSideGateOne, highSideGateTwo;
  logic bootstrapOne, bootstrapTwo, timingResistorDrive, faultActive;
  int fails = 0;
  int compares = 0;
  int cyc = 0;
  wire [5:0] outs = {lowSideGateOne, lowSideGateTwo, highSideGateOne,
    highSideGateTwo, timingResistorDrive, faultActive};
  // lockout, shutdown, pull, then expected outs
  logic [8:0] rows [6] = '{9'h100, 9'h032, 9'h072, 9'h0C1, 9'h001, 9'h100};
  fbds_sequencer #(.SHORT_DEAD(1'b1)) uut (
    .clock(clock),
    .nrst(nrst),
    .supplyLockoutState(supplyLockoutState),
    .rampAboveLower(rampAboveLower),
    .rampAboveUpper(rampAboveUpper),
    .rampBelowShutdown(rampBelowShutdown),
    .latchedShutdownIn(latchedShutdownIn),
    .lowSideGateOne(lowSideGateOne),
    .lowSideGateTwo(lowSideGateTwo),
    .highSideGateOne(highSideGateOne),
    .highSideGateTwo(highSideGateTwo),
    .bootstrapOne(bootstrapOne),
    .bootstrapTwo(bootstrapTwo),
    .timingResistorDrive(timingResistorDrive),
    .faultActive(faultActive)
  );
  fbds_ramp_model ramp (.clock(clock), .drive(timingResistorDrive),
    .pull(pull), .uv(supplyLockoutState), .aboveLower(rampAboveLower),
    .aboveUpper(rampAboveUpper), .belowShutdown(rampBelowShutdown));
  ////////////////////////////////////////
  initial begin
    forever #2.5 clock = ~clock;
  end
  task automatic check(input string nm, input logic [5:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic waitUp(input bit one);
    int n;
    n = 0;
    while ((one ? highSideGateOne : highSideGateTwo) !== 1'b1 && n < 999) begin
      @(negedge clock);
      n++;
    end
  endtask
  task conclude();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // hang guard, run needs about 1050 cycles
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fails++;
      conclude();
    end
  end
  initial begin
    repeat (8) @(negedge clock);
    nrst = 1'b1;
    foreach (rows[i]) begin
      {supplyLockoutState, latchedShutdownIn, pull} = rows[i][8:6];
      repeat (5) @(negedge clock);
      check("row", outs, rows[i][5:0]);
    end
    supplyLockoutState = 1'b0;
    waitUp(1'b0);
    check("pairA", outs, 6'h26);
    waitUp(1'b1);
    check("pairB", outs, 6'h18);
    waitUp(1'b0);
    check("pairA2", outs, 6'h26);
    latchedShutdownIn = 1'b1;
    repeat (2) @(negedge clock);
    check("trip", outs, 6'h01);
    latchedShutdownIn = 1'b0;
    pull = 1'b1;
    nrst = 1'b0;
    @(negedge clock);
    check("reset", outs, 6'h00);
    nrst = 1'b1;
    repeat (5) @(negedge clock);
    check("halt", outs, 6'h32);
    pull = 1'b0;
    waitUp(1'b0);
    check("resume", outs, 6'h26);
    conclude();
  end
endmodule
bind fbds_sequencer fbds_sequencer_checker #(.SHORT_DEAD(SHORT_DEAD)) chk (
  .clock(clock),
  .nrst(nrst),
  .supplyLockoutState(supplyLockoutState),
  .rampAboveLower(rampAboveLower),
  .rampAboveUpper(rampAboveUpper),
  .rampBelowShutdown(rampBelowShutdown),
  .latchedShutdownIn(latchedShutdownIn),
  .lowSideGateOne(lowSideGateOne),
  .lowSideGateTwo(lowSideGateTwo),
  .highSideGateOne(highSideGateOne),
  .highSideGateTwo(highSideGateTwo),
  .bootstrapOne(bootstrapOne),
  .bootstrapTwo(bootstrapTwo),
  .timingResistorDrive(timingResistorDrive),
  .faultActive(faultActive)
);
